// ==== hw/pat_translate.sv ====
// PCIe/AXI4 address translation: master windows and slave windows
// Summary of operation
// R1: Six inbound tables, separate from slave tables
// R2: Endpoint: each 32-bit BAR uses same-index table
// R3: Adjacent BARs combine into one 64-bit BAR
// R4: 64-bit pairs use tables 0, 2, 4
// R5: Endpoint hit: BAR offset plus AXI base
// R6: Root port matches full 64-bit PCIe address
// R7: Root port hit: add table AXI base
// R8: 16 KB BAR0/1 goes to bridge config space
// R9: With windows, in-window requests go to translation
// R10: Without windows, BAR0/1 misses go to translation
// R11: Drop bits above size, add translation base
// R12: Six slave tables, AXI address to PCIe
// R13: Slave hit: offset plus 64-bit PCIe base
// R14: Windows power-of-two sized and aligned
// R15: Unmatched request not forwarded, flagged error
module pat_translate
    import pat_pkg::*;
#(
    parameter int TABLES = NUM_TABLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire pat_pkg::pat_mode_e mode_in,
    // Per-table configuration, flattened by table index, plus root port config BAR and window
    input wire logic [TABLES-1:0] bar_en_in,
    input wire logic [TABLES-1:0] bar_is64_in,
    input wire logic [TABLES*pat_pkg::PCIE_AW-1:0] bar_base_in,
    input wire logic [TABLES*pat_pkg::SIZE_W-1:0] bar_log2_size_in,
    input wire logic [TABLES*pat_pkg::AXI_AW-1:0] bar_axi_base_in,
    input wire logic rp_cfg_bar_en_in,
    input wire logic [pat_pkg::PCIE_AW-1:0] rp_cfg_bar_base_in,
    input wire logic rp_windows_present_in,
    input wire logic [pat_pkg::PCIE_AW-1:0] rp_win_base_in,
    input wire logic [pat_pkg::SIZE_W-1:0] rp_win_log2_size_in,
    input wire logic [TABLES-1:0] slv_en_in,
    input wire logic [TABLES*pat_pkg::AXI_AW-1:0] slv_base_in,
    input wire logic [TABLES*pat_pkg::SIZE_W-1:0] slv_log2_size_in,
    input wire logic [TABLES*pat_pkg::PCIE_AW-1:0] slv_pcie_base_in,
    // Inbound PCIe request
    input wire logic pcie_req_valid_in,
    input wire logic [pat_pkg::PCIE_AW-1:0] pcie_req_addr_in,
    output logic mst_valid_out,
    output logic [pat_pkg::AXI_AW-1:0] mst_addr_out,
    output logic [pat_pkg::TBL_IDX_W-1:0] mst_table_out,
    output logic cfg_valid_out,
    output logic [pat_pkg::PCIE_AW-1:0] cfg_offset_out,
    output logic pcie_ur_out,
    // AXI4 slave request from fabric
    input wire logic axi_req_valid_in,
    input wire logic [pat_pkg::AXI_AW-1:0] axi_req_addr_in,
    output logic pcie_valid_out,
    output logic [pat_pkg::PCIE_AW-1:0] pcie_addr_out,
    output logic [pat_pkg::TBL_IDX_W-1:0] slv_table_out,
    output logic axi_err_out
);
    import pat_pkg::*;

    logic [TABLES-1:0] tbl_en;
    logic [TABLES-1:0] mst_hit;
    logic [TABLES-1:0] slv_hit;
    logic [AXI_AW-1:0] mst_xlat [TABLES];
    logic [PCIE_AW-1:0] slv_xlat [TABLES];
    logic [SIZE_W-1:0] eff_size [TABLES];
    logic [PCIE_AW-1:0] eff_base [TABLES];

    // Odd table disabled when its even partner claims a 64-bit pair
    always_comb begin
        for (int i = 0; i < TABLES; i++) begin
            eff_size[i] = bar_log2_size_in[i*SIZE_W +: SIZE_W];
            eff_base[i] = bar_base_in[i*PCIE_AW +: PCIE_AW];
            if (i % 2 == 1) begin
                tbl_en[i] = bar_en_in[i] && !bar_is64_in[i-1]; // [R4]
            end else begin
                tbl_en[i] = bar_en_in[i]; // [R2] [R3]
            end
        end
    end

    for (genvar g = 0; g < TABLES; g++) begin : g_win
        pat_window_match #(
            .IN_W(PCIE_AW),
            .OUT_W(AXI_AW)
        ) u_mst (
            .enable_in(tbl_en[g]),
            .addr_in(pcie_req_addr_in),
            .base_in(eff_base[g]),
            .log2_size_in(eff_size[g]),
            .trans_base_in(bar_axi_base_in[g*AXI_AW +: AXI_AW]),
            .hit_out(mst_hit[g]),
            .trans_addr_out(mst_xlat[g])
        ); // [R1] [R5] [R6] [R7]
        pat_window_match #(
            .IN_W(AXI_AW),
            .OUT_W(PCIE_AW)
        ) u_slv (
            .enable_in(slv_en_in[g]),
            .addr_in(axi_req_addr_in),
            .base_in(slv_base_in[g*AXI_AW +: AXI_AW]),
            .log2_size_in(slv_log2_size_in[g*SIZE_W +: SIZE_W]),
            .trans_base_in(slv_pcie_base_in[g*PCIE_AW +: PCIE_AW]),
            .hit_out(slv_hit[g]),
            .trans_addr_out(slv_xlat[g])
        ); // [R12] [R13]
    end

    // Inbound path state
    logic mst_valid_r, mst_valid_nxt;
    logic [AXI_AW-1:0] mst_addr_r, mst_addr_nxt;
    logic [TBL_IDX_W-1:0] mst_table_r, mst_table_nxt;
    logic cfg_valid_r, cfg_valid_nxt;
    logic [PCIE_AW-1:0] cfg_offset_r, cfg_offset_nxt;
    logic pcie_ur_r, pcie_ur_nxt;
    logic cfg_hit;
    logic win_ok;
    logic [PCIE_AW-1:0] cfg_mask;
    logic [PCIE_AW-1:0] win_mask;
    logic found;

    always_comb begin
        cfg_mask = pat_offset_mask(CFG_SPACE_LOG2);
        win_mask = pat_offset_mask(rp_win_log2_size_in);
        cfg_hit = (mode_in == PAT_MODE_ROOT_PORT) && rp_cfg_bar_en_in &&
                  ((pcie_req_addr_in & ~cfg_mask) == (rp_cfg_bar_base_in & ~cfg_mask));
        if (mode_in == PAT_MODE_ENDPOINT) begin
            win_ok = 1'b1;
        end else if (rp_windows_present_in) begin
            win_ok = (pcie_req_addr_in & ~win_mask) == (rp_win_base_in & ~win_mask); // [R9]
        end else begin
            win_ok = !cfg_hit; // [R10]
        end
        mst_valid_nxt = 1'b0;
        mst_addr_nxt = mst_addr_r;
        mst_table_nxt = mst_table_r;
        cfg_valid_nxt = 1'b0;
        cfg_offset_nxt = cfg_offset_r;
        pcie_ur_nxt = 1'b0;
        found = 1'b0;
        if (pcie_req_valid_in) begin
            if (cfg_hit) begin
                cfg_valid_nxt = 1'b1; // [R8]
                cfg_offset_nxt = pcie_req_addr_in & cfg_mask;
            end else begin
                // Lowest table wins when windows overlap
                for (int i = TABLES - 1; i >= 0; i--) begin
                    if (mst_hit[i] && win_ok) begin
                        found = 1'b1;
                        mst_addr_nxt = mst_xlat[i]; // [R5] [R7] [R11]
                        mst_table_nxt = TBL_IDX_W'(i);
                    end
                end
                mst_valid_nxt = found;
                pcie_ur_nxt = !found; // [R15]
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mst_valid_r <= 1'b0;
            mst_addr_r <= '0;
            mst_table_r <= '0;
            cfg_valid_r <= 1'b0;
            cfg_offset_r <= '0;
            pcie_ur_r <= 1'b0;
        end else begin
            mst_valid_r <= mst_valid_nxt;
            mst_addr_r <= mst_addr_nxt;
            mst_table_r <= mst_table_nxt;
            cfg_valid_r <= cfg_valid_nxt;
            cfg_offset_r <= cfg_offset_nxt;
            pcie_ur_r <= pcie_ur_nxt;
        end
    end

    // Slave path state
    logic pcie_valid_r, pcie_valid_nxt;
    logic [PCIE_AW-1:0] pcie_addr_r, pcie_addr_nxt;
    logic [TBL_IDX_W-1:0] slv_table_r, slv_table_nxt;
    logic axi_err_r, axi_err_nxt;
    logic slv_found;

    always_comb begin
        pcie_valid_nxt = 1'b0;
        pcie_addr_nxt = pcie_addr_r;
        slv_table_nxt = slv_table_r;
        axi_err_nxt = 1'b0;
        slv_found = 1'b0;
        if (axi_req_valid_in) begin
            for (int i = TABLES - 1; i >= 0; i--) begin
                if (slv_hit[i]) begin
                    slv_found = 1'b1;
                    pcie_addr_nxt = slv_xlat[i]; // [R13]
                    slv_table_nxt = TBL_IDX_W'(i);
                end
            end
            pcie_valid_nxt = slv_found;
            // Fabric is expected to stay inside enabled windows
            axi_err_nxt = !slv_found; // [R15] [R13]
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pcie_valid_r <= 1'b0;
            pcie_addr_r <= '0;
            slv_table_r <= '0;
            axi_err_r <= 1'b0;
        end else begin
            pcie_valid_r <= pcie_valid_nxt;
            pcie_addr_r <= pcie_addr_nxt;
            slv_table_r <= slv_table_nxt;
            axi_err_r <= axi_err_nxt;
        end
    end

    assign mst_valid_out = mst_valid_r;
    assign mst_addr_out = mst_addr_r;
    assign mst_table_out = mst_table_r;
    assign cfg_valid_out = cfg_valid_r;
    assign cfg_offset_out = cfg_offset_r;
    assign pcie_ur_out = pcie_ur_r;
    assign pcie_valid_out = pcie_valid_r;
    assign pcie_addr_out = pcie_addr_r;
    assign slv_table_out = slv_table_r;
    assign axi_err_out = axi_err_r;
endmodule // pat_translate

// ==== hw/pat_pkg.sv ====
// Constants and types for the PCIe/AXI4 address translation block
package pat_pkg;
    localparam int NUM_TABLES = 6;
    localparam int PCIE_AW = 64;
    localparam int AXI_AW = 32;
    localparam int SIZE_W = 6;
    // Bridge config space behind BAR0/1 in root port mode: 16 KB
    localparam logic [SIZE_W-1:0] CFG_SPACE_LOG2 = 6'h0e;
    localparam logic [11:0] BAR0_CFG_OFFSET = 12'h010;
    localparam logic [11:0] BAR1_CFG_OFFSET = 12'h014;
    localparam int TBL_IDX_W = 3;

    typedef enum logic [1:0] {
        PAT_RT_NONE,
        PAT_RT_AXI_MASTER,
        PAT_RT_BRIDGE_CFG
    } pat_route_e;

    typedef enum logic {
        PAT_MODE_ENDPOINT,
        PAT_MODE_ROOT_PORT
    } pat_mode_e;

    // Mask keeping the low size bits of an address
    function automatic logic [PCIE_AW-1:0] pat_offset_mask(input logic [SIZE_W-1:0] log2_size);
        pat_offset_mask = (64'h0000_0000_0000_0001 << log2_size) - 64'h0000_0000_0000_0001;
    endfunction
endpackage : pat_pkg

// ==== hw/pat_window_match.sv ====
// One translation window: hit decode and offset translation
module pat_window_match
    import pat_pkg::*;
#(
    parameter int IN_W = 64,
    parameter int OUT_W = 32
) (
    input wire logic enable_in,
    input wire logic [IN_W-1:0] addr_in,
    input wire logic [IN_W-1:0] base_in,
    input wire logic [SIZE_W-1:0] log2_size_in,
    input wire logic [OUT_W-1:0] trans_base_in,
    output logic hit_out,
    output logic [OUT_W-1:0] trans_addr_out
);
    import pat_pkg::*;

    logic [IN_W-1:0] mask;
    logic [IN_W-1:0] offset;

    always_comb begin
        mask = IN_W'(pat_offset_mask(log2_size_in));
        offset = addr_in & mask;
        // Power-of-two window, hit compares bits above the size [R14]
        hit_out = enable_in && ((addr_in & ~mask) == (base_in & ~mask));
        // Upper bits dropped, translation base added [R11] [R13]
        // Size cast serves both directions; a part-select breaks when widening
        trans_addr_out = trans_base_in + OUT_W'(offset);
    end
endmodule // pat_window_match

// ==== verif/pat_translate_properties.sv ====
// Checker for the translation block outputs
module pat_translate_properties
    import pat_pkg::*;
#(
    parameter int TABLES = NUM_TABLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire pat_pkg::pat_mode_e mode_in,
    input wire logic [TABLES-1:0] bar_is64_in,
    input wire logic pcie_req_valid_in,
    input wire logic mst_valid_out,
    input wire logic [pat_pkg::TBL_IDX_W-1:0] mst_table_out,
    input wire logic cfg_valid_out,
    input wire logic [pat_pkg::PCIE_AW-1:0] cfg_offset_out,
    input wire logic pcie_ur_out,
    input wire logic axi_req_valid_in,
    input wire logic pcie_valid_out,
    input wire logic [pat_pkg::PCIE_AW-1:0] pcie_addr_out,
    input wire logic axi_err_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_one; pcie_req_valid_in |=> $onehot({mst_valid_out, cfg_valid_out, pcie_ur_out});
    endproperty
    a_one: assert property (p_one) else $error("no single answer");
    property p_quiet; !pcie_req_valid_in |=> !(mst_valid_out || cfg_valid_out || pcie_ur_out);
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_sone; axi_req_valid_in |=> pcie_valid_out ^ axi_err_out; endproperty
    a_sone: assert property (p_sone) else $error("slave answer wrong");
    property p_squiet; !axi_req_valid_in |=> !(pcie_valid_out || axi_err_out); endproperty
    a_squiet: assert property (p_squiet) else $error("slave answer unasked");
    property p_epcfg; pcie_req_valid_in && mode_in == PAT_MODE_ENDPOINT |=> !cfg_valid_out;
    endproperty
    a_epcfg: assert property (p_epcfg) else $error("config route in endpoint");
    property p_cfgr; cfg_valid_out |-> cfg_offset_out[63:14] == '0; endproperty
    a_cfgr: assert property (p_cfgr) else $error("config offset too big");
    property p_hold; !pcie_valid_out |-> $stable(pcie_addr_out); endproperty
    a_hold: assert property (p_hold) else $error("slave address moved");
    property p_odd; mst_valid_out && mst_table_out[0] |-> !bar_is64_in[mst_table_out - 3'h1];
    endproperty
    a_odd: assert property (p_odd) else $error("odd table of pair used");
endmodule // pat_translate_properties

bind pat_translate pat_translate_properties #(.TABLES(TABLES)) i_props (.*);

// ==== verif/pat_requester.sv ====
// Requester model for PCIe and fabric sides
module pat_requester (
    input wire logic clk_in,
    output logic pcie_req_valid_out = 1'b0,
    output logic [63:0] pcie_req_addr_out = '0,
    output logic axi_req_valid_out = 1'b0,
    output logic [31:0] axi_req_addr_out = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic pcie(input logic [63:0] a);
        pcie_req_valid_out = 1'b1;
        pcie_req_addr_out = a;
        @(negedge clk_in);
    endtask
    task automatic axi(input logic [31:0] a);
        axi_req_valid_out = 1'b1;
        axi_req_addr_out = a;
        @(negedge clk_in);
    endtask
    // Released lines show inverted data, never a stale match
    task automatic idle();
        pcie_req_valid_out = 1'b0;
        axi_req_valid_out = 1'b0;
        pcie_req_addr_out = ~pcie_req_addr_out;
        axi_req_addr_out = ~axi_req_addr_out;
        @(negedge clk_in);
    endtask
endmodule // pat_requester

// ==== verif/pat_translate_tb.sv ====
// Self-checking bench for the translation block
module pat_translate_tb;
    import pat_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rstn_in = 1'b0;
    pat_mode_e mode_in = PAT_MODE_ENDPOINT;
    logic [5:0] bar_en_in = '0, bar_is64_in = '0, slv_en_in = '0;
    logic [383:0] bar_base_in = '0, slv_pcie_base_in = '0;
    logic [35:0] bar_log2_size_in = '0, slv_log2_size_in = '0;
    logic [191:0] bar_axi_base_in = '0, slv_base_in = '0;
    logic rp_cfg_bar_en_in = 1'b0, rp_windows_present_in = 1'b0;
    logic [63:0] rp_cfg_bar_base_in = '0, rp_win_base_in = '0;
    logic [5:0] rp_win_log2_size_in = '0;
    logic pcie_req_valid_in, axi_req_valid_in, mst_valid_out, cfg_valid_out, pcie_ur_out;
    logic pcie_valid_out, axi_err_out;
    logic [63:0] pcie_req_addr_in, cfg_offset_out, pcie_addr_out;
    logic [31:0] axi_req_addr_in, mst_addr_out;
    logic [2:0] mst_table_out, slv_table_out;
    int err_total = 0, num_checks = 0, cyc = 0;
    pat_translate i_dut (.*);
    pat_requester i_req (.clk_in(clk_in), .pcie_req_valid_out(pcie_req_valid_in),
        .pcie_req_addr_out(pcie_req_addr_in), .axi_req_valid_out(axi_req_valid_in),
        .axi_req_addr_out(axi_req_addr_in));
    always #20 clk_in = ~clk_in;
    function automatic logic [63:0] bs(input int i);
        return 64'h1000_0000 | (64'(i) << 16);
    endfunction
    function automatic logic [31:0] ax(input int i);
        return 32'h4000_0000 | (32'(i) << 24);
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    // k: 0 master, 1 config space, 2 unsupported
    task automatic pc(input logic [63:0] a, input int k, input logic [63:0] v,
        input logic [2:0] t);
        i_req.pcie(a);
        chk({mst_valid_out, cfg_valid_out, pcie_ur_out}, 64'(3'h4 >> k));
        if (k == 0) begin
            chk(mst_addr_out, v);
            chk(mst_table_out, t);
        end
        if (k == 1) begin
            chk(cfg_offset_out, v);
        end
    endtask
    task automatic sl(input logic [31:0] a, input logic h, input logic [63:0] v,
        input logic [2:0] t);
        i_req.axi(a);
        chk({pcie_valid_out, axi_err_out}, {h, !h});
        if (h) begin
            chk(pcie_addr_out, v);
            chk(slv_table_out, t);
        end
    endtask
    task automatic sc_ep();
        // Config BAR overlaps table 0 but must be ignored in endpoint mode
        rp_cfg_bar_en_in = 1'b1;
        rp_cfg_bar_base_in = bs(0) | 64'h0000_c000;
        for (int i = 0; i < 6; i++) begin
            bar_en_in[i] = 1'b1;
            bar_base_in[i*64+:64] = bs(i);
            bar_log2_size_in[i*6+:6] = 6'h10;
            bar_axi_base_in[i*32+:32] = ax(i);
        end
        for (int i = 0; i < 6; i++) begin
            pc(bs(i) + 64'hfff0, 0, ax(i) + 32'hfff0, 3'(i));
        end
        pc(bs(6), 2, '0, 3'h0);
        bar_is64_in = 6'h15;
        for (int i = 0; i < 6; i += 2) begin
            bar_base_in[i*64+:64] = 64'haaaa_aaaa_0000_0000 | bs(i);
            pc(64'haaaa_aaaa_0000_0010 | bs(i), 0, ax(i) + 32'h10, 3'(i));
            pc(bs(i), 2, '0, 3'h0);
            pc(bs(i + 1), 2, '0, 3'h0);
        end
        bar_is64_in = '0;
    endtask
    task automatic sc_rp();
        mode_in = PAT_MODE_ROOT_PORT;
        rp_cfg_bar_en_in = 1'b1;
        rp_cfg_bar_base_in = 64'h0000_0001_0000_0000;
        bar_base_in[63:0] = '0;
        bar_log2_size_in[5:0] = 6'h14;
        pc(64'h0000_0001_0000_3ffc, 1, 64'h3ffc, 3'h0);
        pc(64'h0000_0001_0000_4000, 2, '0, 3'h0);
        pc(64'h1010, 0, 64'h4000_1010, 3'h0);
        pc(64'h8000_0000_0000_1010, 2, '0, 3'h0);
        rp_windows_present_in = 1'b1;
        rp_win_base_in = 64'h1000_0000;
        rp_win_log2_size_in = 6'h18;
        pc(64'h1010, 2, '0, 3'h0);
        pc(bs(1) | 64'h20, 0, ax(1) + 32'h20, 3'h1);
        pc(64'h0000_0001_0000_0004, 1, 64'h4, 3'h0);
        i_req.idle();
    endtask
    task automatic sc_slv();
        for (int i = 0; i < 6; i++) begin
            slv_en_in[i] = 1'b1;
            slv_base_in[i*32+:32] = 32'h8000_0000 | (32'(i) << 20);
            slv_log2_size_in[i*6+:6] = 6'h14;
            slv_pcie_base_in[i*64+:64] = 64'haaaa_aaa0_0000_0000 | (64'(i) << 32);
        end
        for (int i = 0; i < 6; i++) begin
            sl(32'h8000_1010 | (32'(i) << 20), 1'b1,
                64'haaaa_aaa0_0000_1010 | (64'(i) << 32), 3'(i));
        end
        sl(32'h800f_ffff, 1'b1, 64'haaaa_aaa0_000f_ffff, 3'h0);
        slv_en_in[5] = 1'b0;
        sl(32'h8050_0000, 1'b0, '0, 3'h0);
        sl(32'h1010, 1'b0, '0, 3'h0);
        i_req.idle();
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Whole run is well under a hundred cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        rstn_in = 1'b1;
        sc_ep();
        sc_rp();
        sc_slv();
        rstn_in = 1'b0;
        @(negedge clk_in);
        chk({mst_valid_out, pcie_valid_out, mst_addr_out, pcie_ur_out}, '0);
        rstn_in = 1'b1;
        pc(64'h0000_0001_0000_0008, 1, 64'h8, 3'h0);
        i_req.idle();
        stop_test();
    end
endmodule // pat_translate_tb
